// ===== include/atp_pkg.sv
// Package with the register map, select codes and carrier types of the block.
package atp_pkg;

   // ======================================================================
   // Register offsets, field positions and values after reset.
   // ======================================================================
   localparam logic [7:0] ATP_ADDR_SEL      = 8'h38;
   localparam logic [7:0] ATP_ADDR_DAC1     = 8'h39;
   localparam logic [7:0] ATP_ADDR_DAC2     = 8'h3A;
   localparam logic [7:0] ATP_ADDR_ADC      = 8'h3B;
   localparam logic [7:0] ATP_ADDR_PROD     = 8'h3C;
   localparam logic [7:0] ATP_SEL_RST       = 8'h00;
   localparam logic [5:0] ATP_DAC_RST       = 6'h00;
   localparam logic [7:0] ATP_PROD_RST      = 8'hFF;
   localparam logic [7:0] ATP_ADC_RST       = 8'h00;
   localparam logic [7:0] ATP_RD_IDLE       = 8'h00;
   localparam int         ATP_FIRST_SEL_LSB = 4;
   localparam int         ATP_SECOND_SEL_LSB = 0;
   localparam int         ATP_NIB_W         = 4;
   localparam int         ATP_DAC_W         = 6;
   localparam logic [1:0] ATP_DAC_RSVD_RD   = 2'h0;

   // ======================================================================
   // Source select codes, shared by both auxiliary pins.
   // ======================================================================
   typedef enum logic [3:0] {
      ATP_SRC_TRISTATE = 4'h0,
      ATP_SRC_DAC      = 4'h1,
      ATP_SRC_CORR     = 4'h2,
      ATP_SRC_RSVD3    = 4'h3,
      ATP_SRC_MINLVL   = 4'h4,
      ATP_SRC_ADC_I    = 4'h5,
      ATP_SRC_ADC_Q    = 4'h6,
      ATP_SRC_RSVD7    = 4'h7,
      ATP_SRC_PROD     = 4'h8,
      ATP_SRC_RSVD9    = 4'h9,
      ATP_SRC_HIGH     = 4'hA,
      ATP_SRC_LOW      = 4'hB,
      ATP_SRC_TX       = 4'hC,
      ATP_SRC_RX       = 4'hD,
      ATP_SRC_SUBC     = 4'hE,
      ATP_SRC_TBUS     = 4'hF
   } atp_src_sel_t;

   // Analog route towards the pin's current-source driver.
   typedef enum logic [2:0] {
      ATP_ANA_NONE   = 3'h0,
      ATP_ANA_DAC    = 3'h1,
      ATP_ANA_CORR   = 3'h2,
      ATP_ANA_MINLVL = 3'h3,
      ATP_ANA_ADC_I  = 3'h4,
      ATP_ANA_ADC_Q  = 3'h5,
      ATP_ANA_PROD   = 3'h6
   } atp_ana_t;

   // ======================================================================
   // Carriers.
   // ======================================================================
   typedef struct packed {
      logic     level;
      logic     oe;
      logic     ana_en;
      atp_ana_t ana_src;
   } atp_pin_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } atp_bus_req_t;

   typedef struct packed {
      logic       transmit_active_flag;
      logic       receive_active_flag;
      logic       subcarrier_detected;
      logic [7:0] test_bus;
      logic [2:0] test_bus_bit_choice;
   } atp_status_t;

endpackage

// ===== rtl/atp_aux_test_pin_select.sv
// Auxiliary test pin source select with its test DAC and ADC registers.
`timescale 1ns/100ps

module atp_aux_test_pin_select
   import atp_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 reset,
   // Register port.
   input  wire atp_pkg::atp_bus_req_t bus_req,
   output logic [7:0]                rd_data,
   // Status from the transceiver logic, same clock.
   input  wire atp_pkg::atp_status_t  status,
   // Raw ADC samples from the analog front end, asynchronous.
   input  wire logic [3:0]           adc_i_sample,
   input  wire logic [3:0]           adc_q_sample,
   // Auxiliary pins and the codes for the two test DACs.
   output atp_pkg::atp_pin_t         first_test_out_pin,
   output atp_pkg::atp_pin_t         second_test_out_pin,
   output logic [5:0]                first_test_dac_value,
   output logic [5:0]                second_test_dac_value
);
   import atp_pkg::*;

   // ======================================================================
   // Register state.
   // ======================================================================
   logic [7:0] aux_output_select_r;
   logic [7:0] aux_output_select_nxt;
   logic [5:0] dac1_r;
   logic [5:0] dac2_r;
   logic [7:0] prod_r;
   logic [7:0] adc_meta_r;
   logic [7:0] iq_adc_sample_r;
   logic [7:0] rd_data_r;

   logic       wr_sel;
   logic       wr_dac1;
   logic       wr_dac2;
   logic       wr_prod;

   // Write decode; the bus never has to wait.
   assign wr_sel  = bus_req.wr && (bus_req.addr == ATP_ADDR_SEL);
   assign wr_dac1 = bus_req.wr && (bus_req.addr == ATP_ADDR_DAC1);
   assign wr_dac2 = bus_req.wr && (bus_req.addr == ATP_ADDR_DAC2);
   assign wr_prod = bus_req.wr && (bus_req.addr == ATP_ADDR_PROD);

   // The pins are fed from the next select value, so a write moves the pin
   // on the same edge that stores it, with no extra cycle of lag.
   assign aux_output_select_nxt = wr_sel ? bus_req.wdata
                                         : aux_output_select_r;

   // Select register, both nibbles writable.
   always_ff @(posedge clk) begin
      if (reset) begin
         aux_output_select_r <= ATP_SEL_RST;
      end else begin
         aux_output_select_r <= aux_output_select_nxt;
      end
   end

   // Test DAC codes; top two bits of each word are dropped on write.
   always_ff @(posedge clk) begin
      if (reset) begin
         dac1_r <= ATP_DAC_RST;
         dac2_r <= ATP_DAC_RST;
      end else begin
         if (wr_dac1) begin
            dac1_r <= bus_req.wdata[ATP_DAC_W-1:0];
         end
         if (wr_dac2) begin
            dac2_r <= bus_req.wdata[ATP_DAC_W-1:0];
         end
      end
   end

   // Production register keeps whatever the test floor writes to it.
   always_ff @(posedge clk) begin
      if (reset) begin
         prod_r <= ATP_PROD_RST;
      end else if (wr_prod) begin
         prod_r <= bus_req.wdata;
      end
   end

   // ADC samples come from another timing domain: two flops before use.
   always_ff @(posedge clk) begin
      if (reset) begin
         adc_meta_r      <= ATP_ADC_RST;
         iq_adc_sample_r <= ATP_ADC_RST;
      end else begin
         adc_meta_r      <= {adc_i_sample, adc_q_sample};
         iq_adc_sample_r <= adc_meta_r;
      end
   end

   // ======================================================================
   // Read port: data stand in the cycle after the strobe, zero otherwise.
   // ======================================================================
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_r <= ATP_RD_IDLE;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            ATP_ADDR_SEL: begin
               rd_data_r <= aux_output_select_r;
            end
            ATP_ADDR_DAC1: begin
               rd_data_r <= {ATP_DAC_RSVD_RD, dac1_r};
            end
            ATP_ADDR_DAC2: begin
               rd_data_r <= {ATP_DAC_RSVD_RD, dac2_r};
            end
            ATP_ADDR_ADC: begin
               rd_data_r <= iq_adc_sample_r;
            end
            ATP_ADDR_PROD: begin
               rd_data_r <= prod_r;
            end
            default: begin
               rd_data_r <= ATP_RD_IDLE;
            end
         endcase
      end else begin
         rd_data_r <= ATP_RD_IDLE;
      end
   end

   // ======================================================================
   // Pin routing. Analog codes only steer the current-source driver; the
   // digital driver stays off then, so the two never fight on the pin.
   // ======================================================================
   function automatic atp_pin_t route_pin(input logic [3:0]  sel,
                                          input atp_status_t st);
      atp_pin_t p;
      p = '0;
      case (atp_src_sel_t'(sel))
         ATP_SRC_TRISTATE: begin
            p = '0;
         end
         ATP_SRC_DAC: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_DAC;
         end
         ATP_SRC_CORR: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_CORR;
         end
         ATP_SRC_MINLVL: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_MINLVL;
         end
         ATP_SRC_ADC_I: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_ADC_I;
         end
         ATP_SRC_ADC_Q: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_ADC_Q;
         end
         ATP_SRC_PROD: begin
            p.ana_en  = 1'b1;
            p.ana_src = ATP_ANA_PROD;
         end
         ATP_SRC_HIGH: begin
            p.oe    = 1'b1;
            p.level = 1'b1;
         end
         ATP_SRC_LOW: begin
            p.oe    = 1'b1;
            p.level = 1'b0;
         end
         ATP_SRC_TX: begin
            p.oe    = 1'b1;
            p.level = st.transmit_active_flag;
         end
         ATP_SRC_RX: begin
            p.oe    = 1'b1;
            p.level = st.receive_active_flag;
         end
         ATP_SRC_SUBC: begin
            p.oe    = 1'b1;
            p.level = st.subcarrier_detected;
         end
         ATP_SRC_TBUS: begin
            p.oe    = 1'b1;
            p.level = st.test_bus[st.test_bus_bit_choice];
         end
         default: begin
            p = '0;
         end
      endcase
      return p;
   endfunction

   // Index 0 is the second pin (low nibble), index 1 the first pin.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         atp_pin_t pin_r;
         always_ff @(posedge clk) begin
            if (reset) begin
               pin_r <= '0;
            end else begin
               pin_r <= route_pin(
                  aux_output_select_nxt[g*ATP_NIB_W +: ATP_NIB_W], status);
            end
         end
      end
   endgenerate

   // Outputs, each straight from a flop.
   assign rd_data               = rd_data_r;
   assign first_test_out_pin    = g_pin[1].pin_r;
   assign second_test_out_pin   = g_pin[0].pin_r;
   assign first_test_dac_value  = dac1_r;
   assign second_test_dac_value = dac2_r;

   // ======================================================================
   // Assertions.
   // ======================================================================
   logic [3:0] sel1;
   logic [3:0] sel2;
   assign sel1 = aux_output_select_r[ATP_FIRST_SEL_LSB +: ATP_NIB_W];
   assign sel2 = aux_output_select_r[ATP_SECOND_SEL_LSB +: ATP_NIB_W];

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_sel_reset_value: assert property (
      $fell(reset) |-> aux_output_select_r == ATP_SEL_RST
                       && !first_test_out_pin.oe && !second_test_out_pin.oe)
      else $error("select register or pins not idle after reset");

   a_sel_write_read: assert property (
      bus_req.wr && bus_req.addr == ATP_ADDR_SEL ##1
      bus_req.rd && bus_req.addr == ATP_ADDR_SEL
      |=> rd_data == $past(bus_req.wdata, 2))
      else $error("select register did not read back the written value");

   a_fixed_levels: assert property (
      (sel1 == ATP_SRC_HIGH |-> first_test_out_pin.oe
                                && first_test_out_pin.level)
      and (sel1 == ATP_SRC_LOW |-> first_test_out_pin.oe
                                   && !first_test_out_pin.level)
      and (sel1 == ATP_SRC_TRISTATE |-> !first_test_out_pin.oe
                                        && !first_test_out_pin.ana_en))
      else $error("fixed level or tri-state wrong on first pin");

   a_dac_route: assert property (
      sel1 == ATP_SRC_DAC |-> first_test_out_pin.ana_en
                              && first_test_out_pin.ana_src == ATP_ANA_DAC
                              && !first_test_out_pin.oe)
      else $error("first pin not routed to its test DAC");

   a_analog_codes: assert property (
      (sel1 == ATP_SRC_ADC_Q |-> first_test_out_pin.ana_src == ATP_ANA_ADC_Q)
      and (sel1 == ATP_SRC_MINLVL
           |-> first_test_out_pin.ana_src == ATP_ANA_MINLVL)
      and (sel1 inside {ATP_SRC_RSVD3, ATP_SRC_RSVD7, ATP_SRC_RSVD9}
           |-> !first_test_out_pin.oe && !first_test_out_pin.ana_en))
      else $error("analog or reserved code routed wrongly");

   a_tx_flag_route: assert property (
      sel1 == ATP_SRC_TX && $past(sel1) == ATP_SRC_TX
      |-> first_test_out_pin.oe
          && first_test_out_pin.level == $past(status.transmit_active_flag))
      else $error("transmit-active flag not on first pin");

   a_rx_flag_route: assert property (
      sel2 == ATP_SRC_RX
      |-> second_test_out_pin.oe
          && second_test_out_pin.level == $past(status.receive_active_flag))
      else $error("receive-active flag not on second pin");

   a_subc_flag_route: assert property (
      sel1 == ATP_SRC_SUBC
      |-> first_test_out_pin.level == $past(status.subcarrier_detected))
      else $error("subcarrier flag not on first pin");

   a_test_bus_bit: assert property (
      sel2 == ATP_SRC_TBUS
      |-> second_test_out_pin.level
          == $past(status.test_bus[status.test_bus_bit_choice]))
      else $error("wrong test bus bit on second pin");

   a_second_same_code: assert property (
      sel1 == sel2 && $past(sel1) == $past(sel2)
      |-> first_test_out_pin == second_test_out_pin)
      else $error("second pin decodes differently from the first");

   a_dac1_store: assert property (
      bus_req.wr && bus_req.addr == ATP_ADDR_DAC1
      |=> first_test_dac_value == $past(bus_req.wdata[5:0]))
      else $error("first DAC value not stored");

   a_dac2_readback: assert property (
      bus_req.rd && bus_req.addr == ATP_ADDR_DAC2
      |=> rd_data == {2'h0, $past(second_test_dac_value)})
      else $error("second DAC read wrong or reserved bits not zero");

   a_adc_sample_read: assert property (
      bus_req.rd && bus_req.addr == ATP_ADDR_ADC
      |=> rd_data == $past({adc_i_sample, adc_q_sample}, 3))
      else $error("ADC register does not show the synchronised sample");

   a_prod_reset: assert property (
      $fell(reset) |-> prod_r == ATP_PROD_RST)
      else $error("production register did not reset to all ones");

   a_sel_takes_effect: assert property (
      bus_req.wr && bus_req.addr == ATP_ADDR_SEL
      && bus_req.wdata[7:4] == ATP_SRC_HIGH
      |=> first_test_out_pin.oe && first_test_out_pin.level)
      else $error("select write did not reach the pin at once");

   a_read_one_cycle: assert property (
      !bus_req.rd |=> rd_data == ATP_RD_IDLE)
      else $error("read data stood longer than one cycle");

   c_tx_on_pin: cover property (
      sel1 == ATP_SRC_TX ##1 first_test_out_pin.level);
   c_dac_both: cover property (
      sel1 == ATP_SRC_DAC && sel2 == ATP_SRC_DAC);
   c_tbus_bit: cover property (
      sel2 == ATP_SRC_TBUS ##1 second_test_out_pin.level);
   c_adc_read: cover property (
      bus_req.rd && bus_req.addr == ATP_ADDR_ADC ##1 rd_data != 8'h00);

endmodule

// ===== dv/atp_aux_test_pin_select_tb.sv
// Self-checking testbench for the auxiliary test pin select block.
`timescale 1ns/100ps

module atp_aux_test_pin_select_tb;
   import atp_pkg::*;

   // =====================================================================
   // Clock, reset and connections to the block.
   // =====================================================================
   logic         clk;
   logic         reset;
   atp_bus_req_t bus_req;
   logic [7:0]   rd_data;
   atp_status_t  status;
   logic [3:0]   adc_i;
   logic [3:0]   adc_q;
   atp_pin_t     pin1;
   atp_pin_t     pin2;
   logic [5:0]   dac1;
   logic [5:0]   dac2;
   int           err_count;
   int           checks_done;
   logic [7:0]   rd_val;

   // Block under test, every input driven by the bench.
   atp_aux_test_pin_select DUT (
      .clk                   (clk),
      .reset                 (reset),
      .bus_req               (bus_req),
      .rd_data               (rd_data),
      .status                (status),
      .adc_i_sample          (adc_i),
      .adc_q_sample          (adc_q),
      .first_test_out_pin    (pin1),
      .second_test_out_pin   (pin2),
      .first_test_dac_value  (dac1),
      .second_test_dac_value (dac2)
   );

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // =====================================================================
   // Compare, bus and model tasks.
   // =====================================================================
   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_pin(input string what, input atp_pin_t exp,
                          input atp_pin_t got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write; returns just after the edge that takes it.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req.addr  <= a;
      bus_req.wdata <= d;
      bus_req.wr    <= 1'b1;
      @(posedge clk);
      bus_req.wr    <= 1'b0;
      #1;
   endtask

   // One-cycle read; the data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_req.addr <= a;
      bus_req.rd   <= 1'b1;
      @(posedge clk);
      bus_req.rd   <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic chk_reg(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
      rd_reg(a, rd_val);
      chk8(what, exp, rd_val);
   endtask

   // Expected pin carrier for one select code, from the current status.
   function automatic atp_pin_t exp_pin(input logic [3:0] c);
      atp_pin_t p;
      p = '0;
      case (c)
         4'hA: begin p.oe = 1'b1; p.level = 1'b1; end
         4'hB: p.oe = 1'b1;
         4'hC: begin p.oe = 1'b1; p.level = status.transmit_active_flag; end
         4'hD: begin p.oe = 1'b1; p.level = status.receive_active_flag; end
         4'hE: begin p.oe = 1'b1; p.level = status.subcarrier_detected; end
         4'hF: begin
            p.oe    = 1'b1;
            p.level = status.test_bus[status.test_bus_bit_choice];
         end
         4'h1: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_DAC; end
         4'h2: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_CORR; end
         4'h4: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_MINLVL; end
         4'h5: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_ADC_I; end
         4'h6: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_ADC_Q; end
         4'h8: begin p.ana_en = 1'b1; p.ana_src = ATP_ANA_PROD; end
         default: p = '0;
      endcase
      return p;
   endfunction

   // =====================================================================
   // Scenarios.
   // =====================================================================
   // Values right after reset, pins quiet.
   task automatic test_reset();
      chk_pin("pin1 reset", '0, pin1);
      chk_pin("pin2 reset", '0, pin2);
      chk_reg("select reset", ATP_ADDR_SEL, 8'h00);
      chk_reg("dac1 reset", ATP_ADDR_DAC1, 8'h00);
      chk_reg("dac2 reset", ATP_ADDR_DAC2, 8'h00);
      chk_reg("adc reset", ATP_ADDR_ADC, 8'h00);
      chk_reg("prod reset", ATP_ADDR_PROD, 8'hFF);
   endtask

   // Every code on both pins, with the second nibble the inverse code.
   task automatic test_codes();
      logic [3:0] c;
      @(posedge clk);
      status.transmit_active_flag <= 1'b1;
      status.receive_active_flag  <= 1'b0;
      status.subcarrier_detected  <= 1'b1;
      status.test_bus             <= 8'hA5;
      status.test_bus_bit_choice  <= 3'h2;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wr_reg(ATP_ADDR_SEL, {c, ~c});
         chk_pin("pin1 code", exp_pin(c), pin1);
         chk_pin("pin2 code", exp_pin(~c), pin2);
      end
      chk_reg("select readback", ATP_ADDR_SEL, 8'hF0);
   endtask

   // Status flags follow with one cycle of lag; test bus bit per choice.
   task automatic test_flags();
      logic [7:0] tb;
      wr_reg(ATP_ADDR_SEL, 8'hCD);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         status.transmit_active_flag <= i[0];
         status.receive_active_flag  <= i[1];
         @(posedge clk);
         #1;
         chk8("tx level", {7'h0, i[0]}, {7'h0, pin1.level});
         chk8("rx level", {7'h0, i[1]}, {7'h0, pin2.level});
      end
      wr_reg(ATP_ADDR_SEL, 8'hEF);
      for (int k = 0; k < 8; k++) begin
         tb = 8'h01 << k;
         @(posedge clk);
         status.test_bus            <= k[0] ? tb : ~tb;
         status.test_bus_bit_choice <= 3'(k);
         status.subcarrier_detected <= ~k[0];
         @(posedge clk);
         #1;
         chk8("tbus level", {7'h0, k[0]}, {7'h0, pin2.level});
         chk8("subc level", {7'h0, ~k[0]}, {7'h0, pin1.level});
      end
   endtask

   // DAC codes, reserved bits, read-only ADC and an unmapped address.
   task automatic test_regs();
      wr_reg(ATP_ADDR_DAC1, 8'hFF);
      chk8("dac1 out", 8'h3F, {2'h0, dac1});
      chk_reg("dac1 rsvd", ATP_ADDR_DAC1, 8'h3F);
      wr_reg(ATP_ADDR_DAC2, 8'hC5);
      chk8("dac2 out", 8'h05, {2'h0, dac2});
      chk_reg("dac2 rsvd", ATP_ADDR_DAC2, 8'h05);
      wr_reg(ATP_ADDR_ADC, 8'hAA);
      @(posedge clk);
      adc_i <= 4'h9;
      adc_q <= 4'h6;
      repeat (4) @(posedge clk);
      chk_reg("adc sample", ATP_ADDR_ADC, 8'h96);
      @(posedge clk);
      #1;
      chk8("rd idle", 8'h00, rd_data);
      chk_reg("unmapped", 8'h40, 8'h00);
      // Write then read the select with no gap; both pins take the DAC code.
      @(posedge clk);
      bus_req.addr  <= ATP_ADDR_SEL;
      bus_req.wdata <= 8'h11;
      bus_req.wr    <= 1'b1;
      @(posedge clk);
      bus_req.wr    <= 1'b0;
      bus_req.rd    <= 1'b1;
      @(posedge clk);
      bus_req.rd    <= 1'b0;
      #1;
      chk8("b2b readback", 8'h11, rd_data);
      chk_pin("pin1 both dac", exp_pin(4'h1), pin1);
      chk_pin("pin2 both dac", exp_pin(4'h1), pin2);
   endtask

   // A reset in mid-run returns select and pins to their quiet state.
   task automatic test_rereset();
      wr_reg(ATP_ADDR_SEL, 8'hAB);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk_pin("pin1 rereset", '0, pin1);
      chk_pin("pin2 rereset", '0, pin2);
      chk_reg("select rereset", ATP_ADDR_SEL, 8'h00);
   endtask

   // =====================================================================
   // Verdict, watchdog and main sequence.
   // =====================================================================
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The tests need about 125 cycles; the 10000-cycle limit means a hang.
   initial begin
      #100000;
      err_count++;
      finish_test();
   end

   initial begin
      clk         = 1'b0;
      reset       = 1'b1;
      bus_req     = '0;
      status      = '0;
      adc_i       = 4'h0;
      adc_q       = 4'h0;
      err_count   = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      #1;
      test_reset();
      test_codes();
      test_flags();
      test_regs();
      test_rereset();
      finish_test();
   end

endmodule
